//--- core/ccs_core.sv
// Common command interpreter: completion tracking, status bytes, queue, setups
// Behaviour
// R01: OPC command sets event bit 0 when done
// R02: Enabled event bit raises summary and service; the code raises service only when sre enables the summary bit
// R03: Pending initiate holds OPC until engine idle
// R04: OPC query queues ASCII one when done
// R05: Queued data sets MAV, maybe service request
// R06: Pending initiate holds query character until idle
// R07: Query stays busy until character is queued
// R08: Talk request sends oldest queued entry out
// R09: Option query answers each slot, model or NONE
// R10: Save and recall setups in slots 0-3
// R11: Each slot holds one full setup image
// R12: Failed recall loads preset; slots start preset
// R13: Reset restores defaults, drops pending work, responses
// R14: Trigger command acts like bus group trigger
// R15: Bus trigger acts only with bus arm source
// R16: Controller should follow slow commands with OPC
// R17: Clear status empties event registers, error queue
// R18: Done means zero pending count and idle engine
module ccs_core
  import ccs_pkg::*;
#(
  parameter int                  SETUP_W = 32,        // Bits of one setup image
  parameter int                  NSLOT   = ccs_pkg::MOD_SLOTS, // Module slots
  parameter int                  QDEPTH  = ccs_pkg::OQ_DEPTH,  // Output queue depth
  parameter logic [SETUP_W-1:0]  PRESET  = '0         // Preset setup image
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // Command request
  input  wire logic                     cmd_valid,
  input  wire ccs_pkg::ccs_cmd_type     cmd_code,
  input  wire logic [1:0]               cmd_slot,
  output logic                          cmd_ready,
  // Overlapped operation tracking
  input  wire logic                     ovl_start,
  input  wire logic                     ovl_done,
  input  wire logic                     meas_idle,
  // Bus trigger
  input  wire logic                     get_in,
  input  wire logic                     arm_src_bus,
  output logic                          bus_trig,
  // Status and enables
  input  wire logic [7:0]               ev_set,
  input  wire logic                     esr_rd,
  input  wire logic [7:0]               ese,
  input  wire logic [7:0]               sre,
  input  wire logic                     err_avail,
  output logic      [7:0]               esr,
  output logic      [7:0]               stb,
  output logic                          err_clear,
  // Output queue to the talker
  input  wire logic                     talk_req,
  output logic                          tx_valid,
  output ccs_pkg::ccs_ent_type          tx_kind,
  output logic      [15:0]              tx_data,
  // Installed modules
  input  wire logic [NSLOT*16-1:0]      mod_id,
  // Setup exchange with the rest of the device
  input  wire logic [SETUP_W-1:0]       cur_setup,
  output logic                          setup_load,
  output logic      [SETUP_W-1:0]       setup_out,
  output logic                          dev_reset
);

  // ****************************************************************
  // Local sizes and checks
  // ****************************************************************
  localparam int PW = $clog2(QDEPTH);    // Queue pointer width
  localparam int IW = $clog2(NSLOT + 1); // Option index width

  if (QDEPTH < 2 || (1 << PW) != QDEPTH || QDEPTH < NSLOT) begin : g_chk_q
    $error("ccs_core: QDEPTH must be a power of two and at least NSLOT");
  end
  if (SETUP_W < 1 || SETUP_W > SETUP_BYTES * 8) begin : g_chk_s
    $error("ccs_core: SETUP_W must fit one setup image");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ccs_state_type                   st;       // Controller state
    logic                            cmd_rdy;  // Accepting commands
    logic [PEND_W-1:0]               pend;     // Overlapped operations in flight
    logic                            opc_wait; // OPC command armed
    logic [7:0]                      esr;      // Event status register
    logic [7:0]                      stb;      // Status byte
    logic [QDEPTH-1:0][ENTRY_W-1:0]  q;        // Output queue storage
    logic [PW-1:0]                   q_rd;     // Read pointer
    logic [PW-1:0]                   q_wr;     // Write pointer
    logic [PW:0]                     q_cnt;    // Entries held
    logic                            tx_vld;   // Entry sent this cycle
    logic [ENTRY_W-1:0]              tx_ent;   // Entry sent
    logic [IW-1:0]                   opt_idx;  // Slot being answered
    logic [1:0]                      slot;     // Setup slot in use
    logic                            ld;       // Setup load pulse
    logic [SETUP_W-1:0]              sout;     // Setup image presented
    logic                            trig;     // Trigger pulse
    logic                            rst_p;    // Device reset pulse
    logic                            eclr;     // Error queue clear pulse
  } ccs_st_type;

  ccs_st_type st_ff;                          // Current state
  ccs_st_type nxt_st;                         // Next state
  // Setup memory ports
  logic                  mem_we;              // Write slot
  logic [SETUP_W:0]      mem_wd;              // Parity and image
  logic                  mem_re;              // Read slot
  logic [SETUP_W:0]      mem_rd;              // Registered read word

  // ****************************************************************
  // Setup memory
  // ****************************************************************
  ccs_setup_mem #(
    .WORD_W (SETUP_W + 1),
    .DEPTH  (SETUP_SLOTS),
    .PRESET ({^PRESET, PRESET})
  ) u_mem (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (mem_we),
    .wr_addr (st_ff.slot),
    .wr_data (mem_wd),
    .rd_en   (mem_re),
    .rd_addr (st_ff.slot),
    .rd_data (mem_rd)
  );

  // Memory strobes come from the state; a bad recall rewrites the preset
  always_comb begin
    mem_re = (st_ff.st == ST_RCLR);                        // R10
    mem_we = (st_ff.st == ST_SAVW);                        // R10
    mem_wd = {^cur_setup, cur_setup};                      // R11
    if (st_ff.st == ST_RCLC && (^mem_rd) != 1'b0) begin
      mem_we = 1'b1;                                       // R12
      mem_wd = {^PRESET, PRESET};                          // R12
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic              done;                 // Nothing outstanding
    logic              take;                 // Command accepted
    logic              push;                 // Enqueue this cycle
    logic [ENTRY_W-1:0] push_ent;            // Entry to enqueue
    logic              pop;                  // Dequeue this cycle
    logic              full;                 // Queue full
    logic [15:0]       mid;                  // Module id of slot
    logic [7:0]        sum;                  // Status byte without service bit
    // Completion: no overlapped work and engine back in idle
    done     = (st_ff.pend == '0) && meas_idle;            // R18 R03 R06
    full     = (st_ff.q_cnt == (PW + 1)'(QDEPTH));
    // Reset is taken even while a query waits, so it can cancel it
    take     = cmd_valid && (st_ff.cmd_rdy || cmd_code == CMD_RST);
    push     = 1'b0;
    push_ent = '0;
    pop      = 1'b0;
    mid      = '0;
    sum      = '0;
    nxt_st   = st_ff;
    // Pulses last one cycle
    nxt_st.tx_vld = 1'b0;
    nxt_st.ld     = 1'b0;
    nxt_st.trig   = 1'b0;
    nxt_st.rst_p  = 1'b0;
    nxt_st.eclr   = 1'b0;
    // Count overlapped operations, saturating both ways
    if (ovl_start && !ovl_done && st_ff.pend != '1) begin
      nxt_st.pend = st_ff.pend + 1'b1;                     // R18
    end else if (ovl_done && !ovl_start && st_ff.pend != '0) begin
      nxt_st.pend = st_ff.pend - 1'b1;                     // R18
    end
    // Armed OPC command fires once everything is done
    if (st_ff.opc_wait && done) begin
      nxt_st.opc_wait = 1'b0;                              // R01
    end
    // Group trigger from the bus, counted only with bus arm source
    if (get_in && arm_src_bus) begin
      nxt_st.trig = 1'b1;                                  // R15
    end
    unique case (st_ff.st)
      ST_IDLE: begin
        // Nothing ongoing; commands are decoded below
      end
      ST_OPQW: begin
        // Query stays busy until its character is really queued
        if (done && !full) begin
          push     = 1'b1;                                 // R04 R06
          push_ent = {ENT_CHAR, ASCII_ONE};                // R04
          nxt_st.st = ST_IDLE;                             // R07
        end
      end
      ST_OPTE: begin
        // One entry per module slot, stalling while the queue is full
        if (!full) begin
          mid  = mod_id[st_ff.opt_idx*16 +: 16];
          push = 1'b1;                                     // R09
          push_ent = (mid == EMPTY_ID) ? {ENT_NONE, NONE_WORD} : {ENT_MODEL, mid}; // R09
          if (st_ff.opt_idx == IW'(NSLOT - 1)) begin
            nxt_st.st = ST_IDLE;
          end else begin
            nxt_st.opt_idx = st_ff.opt_idx + 1'b1;
          end
        end
      end
      ST_SAVW: begin
        // Write issued by the memory strobe this cycle
        nxt_st.st = ST_IDLE;
      end
      ST_RCLR: begin
        // Read issued; data arrives next cycle
        nxt_st.st = ST_RCLC;
      end
      ST_RCLC: begin
        // Parity mismatch counts as a failed recall
        nxt_st.sout = ((^mem_rd) == 1'b0) ? mem_rd[SETUP_W-1:0] : PRESET; // R10 R12
        nxt_st.ld = 1'b1;
        nxt_st.st = ST_IDLE;
      end
      default: begin
        nxt_st.st = ST_IDLE;
      end
    endcase
    // Command decode
    if (take) begin
      unique case (cmd_code)
        CMD_CLS: begin
          nxt_st.eclr = 1'b1;                              // R17
        end
        CMD_OPC: begin
          nxt_st.opc_wait = 1'b1;                          // R01
        end
        CMD_OPQ: begin
          nxt_st.st = ST_OPQW;                             // R07
        end
        CMD_OPT: begin
          nxt_st.st      = ST_OPTE;                        // R09
          nxt_st.opt_idx = '0;
        end
        CMD_SAV: begin
          nxt_st.slot = cmd_slot;                          // R10
          nxt_st.st   = ST_SAVW;
        end
        CMD_RCL: begin
          nxt_st.slot = cmd_slot;                          // R10
          nxt_st.st   = ST_RCLR;
        end
        CMD_TRG: begin
          nxt_st.trig = arm_src_bus;                       // R14 R15
        end
        CMD_RST: begin
          // Defaults back, pending work and owed answers dropped
          nxt_st.st       = ST_IDLE;                       // R13
          nxt_st.pend     = '0;                            // R13
          nxt_st.opc_wait = 1'b0;                          // R13
          nxt_st.q_rd     = '0;                            // R13
          nxt_st.q_wr     = '0;
          nxt_st.q_cnt    = '0;
          nxt_st.sout     = PRESET;                        // R13
          nxt_st.ld       = 1'b1;
          nxt_st.rst_p    = 1'b1;
        end
        default: begin
          // No operation
        end
      endcase
    end
    // Output queue; a reset in this cycle already emptied it
    if (!(take && cmd_code == CMD_RST)) begin
      pop = talk_req && (st_ff.q_cnt != '0);               // R08
      if (pop) begin
        nxt_st.tx_vld = 1'b1;                              // R08
        nxt_st.tx_ent = st_ff.q[st_ff.q_rd];               // R08
        nxt_st.q_rd   = st_ff.q_rd + 1'b1;
      end
      if (push) begin
        nxt_st.q[st_ff.q_wr] = push_ent;
        nxt_st.q_wr          = st_ff.q_wr + 1'b1;
      end
      if (push && !pop) begin
        nxt_st.q_cnt = st_ff.q_cnt + 1'b1;
      end else if (pop && !push) begin
        nxt_st.q_cnt = st_ff.q_cnt - 1'b1;
      end
    end
    // Event register: read or clear status empties it, new events win
    if (esr_rd || (take && cmd_code == CMD_CLS)) begin
      nxt_st.esr = '0;                                     // R17
    end
    nxt_st.esr = nxt_st.esr | ev_set;
    if (st_ff.opc_wait && done) begin
      nxt_st.esr[ESR_OPC] = 1'b1;                          // R01 R03
    end
    // Status byte follows the state it summarises
    sum[STB_EAV] = err_avail && !nxt_st.eclr;
    sum[STB_MAV] = (nxt_st.q_cnt != '0);                   // R05
    sum[STB_ESB] = |(nxt_st.esr & ese);                    // R02
    nxt_st.stb          = sum;
    nxt_st.stb[STB_RQS] = |(sum & sre & ~(8'h01 << STB_RQS)); // R02 R05
    nxt_st.cmd_rdy = (nxt_st.st == ST_IDLE);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff         <= '0;
      st_ff.st      <= ST_IDLE;
      st_ff.cmd_rdy <= 1'b1;
      st_ff.esr     <= ESR_RST;
      st_ff.stb     <= STB_RST;
      st_ff.sout    <= PRESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign cmd_ready  = st_ff.cmd_rdy;
  assign bus_trig   = st_ff.trig;
  assign esr        = st_ff.esr;
  assign stb        = st_ff.stb;
  assign err_clear  = st_ff.eclr;
  assign tx_valid   = st_ff.tx_vld;
  assign tx_kind    = ccs_ent_type'(st_ff.tx_ent[ENTRY_W-1:16]);
  assign tx_data    = st_ff.tx_ent[15:0];
  assign setup_load = st_ff.ld;
  assign setup_out  = st_ff.sout;
  assign dev_reset  = st_ff.rst_p;

endmodule // ccs_core

//--- core/ccs_pkg.sv
// Shared constants and types for the common command and completion status block
package ccs_pkg;

  // ****************************************************************
  // Clock and sizing
  // ****************************************************************
  localparam int CLK_MHZ        = 200;      // Core clock rate
  localparam int SETUP_BYTES    = 4096;     // Nominal size of one stored setup image
  localparam int SETUP_SLOTS    = 4;        // Setup memory locations 0 to 3
  localparam int MOD_SLOTS      = 2;        // Module slots answered by the option query
  localparam int OQ_DEPTH       = 4;        // Output queue entries
  localparam int PEND_W         = 8;        // Width of the overlapped operation count
  localparam int ENTRY_W        = 18;       // Queue entry: kind and 16-bit payload

  // ****************************************************************
  // Bit positions in the event and status bytes
  // ****************************************************************
  localparam int ESR_OPC        = 0;        // Operation complete flag
  localparam int STB_EAV        = 2;        // Error available
  localparam int STB_MAV        = 4;        // Message available
  localparam int STB_ESB        = 5;        // Event summary
  localparam int STB_RQS        = 6;        // Request service / master summary

  // ****************************************************************
  // Reset values and fixed payloads
  // ****************************************************************
  localparam logic [7:0]  ESR_RST     = 8'h00;  // Event register after reset
  localparam logic [7:0]  STB_RST     = 8'h00;  // Status byte after reset
  localparam logic [15:0] ASCII_ONE   = 16'h0031; // Completion character
  localparam logic [15:0] NONE_WORD   = 16'h0000; // Payload sent with an empty slot
  localparam logic [15:0] EMPTY_ID    = 16'h0000; // Module id that marks an empty slot

  // ****************************************************************
  // Commands, queue entry kinds and controller states
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,  // No operation
    CMD_CLS = 4'h1,  // Clear status
    CMD_OPC = 4'h2,  // Operation complete command
    CMD_OPQ = 4'h3,  // Operation complete query
    CMD_OPT = 4'h4,  // Option query
    CMD_SAV = 4'h5,  // Save setup
    CMD_RCL = 4'h6,  // Recall setup
    CMD_RST = 4'h7,  // Reset
    CMD_TRG = 4'h8   // Bus trigger
  } ccs_cmd_type;

  typedef enum logic [1:0] {
    ENT_CHAR  = 2'h0,  // Single character
    ENT_MODEL = 2'h1,  // Installed module number
    ENT_NONE  = 2'h2   // Empty slot word
  } ccs_ent_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,  // Ready for a command
    ST_OPQW = 6'h02,  // Query waiting for completion
    ST_OPTE = 6'h04,  // Emitting option entries
    ST_SAVW = 6'h08,  // Writing a setup slot
    ST_RCLR = 6'h10,  // Reading a setup slot
    ST_RCLC = 6'h20   // Checking recalled data
  } ccs_state_type;

endpackage

//--- core/ccs_setup_mem.sv
// Setup memory: one word per slot, preset at reset, registered read data
module ccs_setup_mem #(
  parameter int                 WORD_W = 33,          // Stored word width
  parameter int                 DEPTH  = 4,           // Number of slots
  parameter logic [WORD_W-1:0]  PRESET = '0           // Word loaded into every slot
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WORD_W-1:0]        wr_data,
  // Read port
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WORD_W-1:0]        rd_data
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][WORD_W-1:0] mem;   // Stored images
    logic [WORD_W-1:0]            rdata; // Registered read word
  } ccs_mem_st_type;

  ccs_mem_st_type st_ff;                 // Current state
  ccs_mem_st_type nxt_st;                // Next state

  // Elaboration check: address must cover the slots
  if (DEPTH < 2) begin : g_chk
    $error("ccs_setup_mem: DEPTH must be at least 2");
  end

  // Next state: write wins the slot, read returns the old word
  always_comb begin
    nxt_st = st_ff;
    if (rd_en) begin
      nxt_st.rdata = st_ff.mem[rd_addr];
    end
    if (wr_en) begin
      nxt_st.mem[wr_addr] = wr_data;
    end
  end

  // Register; every slot starts with the preset image
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        st_ff.mem[i] <= PRESET;
      end
      st_ff.rdata <= PRESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rdata;

endmodule // ccs_setup_mem

//--- testbench/ccs_host_model.sv
// Host controller model: asks the device to talk and keeps the last reply
module ccs_host_model (
  // Clock and bench request
  input wire logic                  clock,
  input wire logic                  ask,
  // Device talker side
  input wire logic                  tx_valid,
  input wire ccs_pkg::ccs_ent_type  tx_kind,
  input wire logic [15:0]           tx_data,
  output logic                      talk_req,
  // Captured reply
  output ccs_pkg::ccs_ent_type      rx_k,
  output logic [15:0]               rx_d
);
  timeunit 1ns;
  timeprecision 100ps;
  import ccs_pkg::*;
  // Talk request trails the bench by one edge so it never moves on the sampling edge
  always_ff @(posedge clock) begin
    talk_req <= ask;
    if (tx_valid) begin
      rx_k <= tx_kind;
      rx_d <= tx_data;
    end
  end
endmodule // ccs_host_model

//--- testbench/ccs_props.sv
// Concurrent checks on the command interpreter ports
module ccs_props #(
  parameter int                 SETUP_W = 32,  // Setup image width
  parameter logic [SETUP_W-1:0] PRESET  = '0   // Preset image
) (
  // Clock, reset and command port
  input wire logic                  clock, sys_rst, cmd_valid, cmd_ready,
  input wire ccs_pkg::ccs_cmd_type  cmd_code,
  // Trigger, status and queue
  input wire logic                  get_in, arm_src_bus, bus_trig, err_clear, talk_req, tx_valid,
  input wire logic [7:0]            ese, sre, esr, stb,
  input wire ccs_pkg::ccs_ent_type  tx_kind,
  input wire logic [15:0]           tx_data,
  // Setup exchange
  input wire logic                  setup_load, dev_reset,
  input wire logic [SETUP_W-1:0]    setup_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import ccs_pkg::*;
  // ************
  // Checks
  // ************
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic tk;  // Command taken at this edge; reset bypasses the ready gate
  assign tk = cmd_valid && (cmd_ready || cmd_code == CMD_RST);
  AST_ESB: assert property (!$past(sys_rst) |-> stb[STB_ESB] == |(esr & $past(ese)))
    else $error("event summary does not follow enabled events");
  AST_RQS: assert property (!$past(sys_rst) |-> stb[STB_RQS] ==
    |({stb[7], stb[5:0]} & {$past(sre[7]), $past(sre[5:0])}))
    else $error("service request does not follow enabled summaries");
  AST_TALK: assert property (talk_req && stb[STB_MAV] && !(tk && cmd_code == CMD_RST)
    |=> tx_valid) else $error("queued entry not sent on talk");
  AST_CHAR: assert property (tx_valid && tx_kind == ENT_CHAR |-> tx_data == ASCII_ONE)
    else $error("completion character wrong");
  AST_TRGA: assert property ((get_in || tk && cmd_code == CMD_TRG) && arm_src_bus
    |=> bus_trig) else $error("bus trigger missing");
  AST_TRGB: assert property (bus_trig |-> $past(arm_src_bus))
    else $error("bus trigger without bus arm source");
  AST_RST: assert property (tk && cmd_code == CMD_RST |=> dev_reset && setup_load &&
    setup_out == PRESET && !stb[STB_MAV]) else $error("reset did not restore defaults");
  AST_CLS: assert property (tk && cmd_code == CMD_CLS |=> err_clear && !stb[STB_EAV])
    else $error("clear status incomplete");
  AST_BUSY: assert property (tk && cmd_code inside {CMD_OPQ, CMD_OPT, CMD_RCL}
    |=> !cmd_ready) else $error("busy command left ready high");
  AST_SAV: assert property (tk && cmd_code == CMD_SAV |=> !cmd_ready ##1 cmd_ready)
    else $error("save did not take one busy cycle");
  COV_OPQ: cover property (tk && cmd_code == CMD_OPQ);
  COV_NONE: cover property (tx_valid && tx_kind == ENT_NONE);
  COV_LOAD: cover property (setup_load && !dev_reset);
endmodule // ccs_props
bind ccs_core ccs_props #(.SETUP_W(SETUP_W), .PRESET(PRESET)) i_props (
  .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_code(cmd_code), .get_in(get_in), .arm_src_bus(arm_src_bus), .bus_trig(bus_trig),
  .err_clear(err_clear), .talk_req(talk_req), .tx_valid(tx_valid), .ese(ese), .sre(sre),
  .esr(esr), .stb(stb), .tx_kind(tx_kind), .tx_data(tx_data), .setup_load(setup_load),
  .dev_reset(dev_reset), .setup_out(setup_out)
);

//--- testbench/tb_top.sv
// Self-checking bench for the command interpreter
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ccs_pkg::*;
  localparam logic [31:0] PRE = 32'h5a5a0f0f;  // Preset image
  logic        clock, sys_rst, cmd_valid, ovl_start, ovl_done, meas_idle, get_in, arm_src_bus;
  logic        esr_rd, err_avail, ask, cmd_ready, bus_trig, err_clear, talk_req, tx_valid;
  logic        setup_load, dev_reset;
  ccs_cmd_type cmd_code;
  ccs_ent_type tx_kind, rx_k;
  logic [1:0]  cmd_slot;
  logic [7:0]  ev_set, ese, sre, esr, stb;
  logic [15:0] tx_data, rx_d;
  logic [31:0] mod_id, cur_setup, setup_out;
  int          fail_count, total_checks, trg_n;
  ccs_core #(.PRESET(PRE)) i_dut (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_slot(cmd_slot), .cmd_ready(cmd_ready), .ovl_start(ovl_start),
    .ovl_done(ovl_done), .meas_idle(meas_idle), .get_in(get_in), .arm_src_bus(arm_src_bus),
    .bus_trig(bus_trig), .ev_set(ev_set), .esr_rd(esr_rd), .ese(ese), .sre(sre),
    .err_avail(err_avail), .esr(esr), .stb(stb), .err_clear(err_clear), .talk_req(talk_req),
    .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_data(tx_data), .mod_id(mod_id),
    .cur_setup(cur_setup), .setup_load(setup_load), .setup_out(setup_out),
    .dev_reset(dev_reset));
  ccs_host_model i_host (.clock(clock), .ask(ask), .tx_valid(tx_valid), .tx_kind(tx_kind),
    .tx_data(tx_data), .talk_req(talk_req), .rx_k(rx_k), .rx_d(rx_d));
  // ************
  // Clock, trigger counter and tasks
  // ************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (bus_trig === 1'b1) trg_n++;
  // Step whole cycles, landing just after the edge
  task automatic tk(int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for a level; a stuck device ends the run
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 50 && s !== 1'b1; i++) tk(1);
    if (s !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask
  // Reset bypasses the ready gate, so it is sent even while busy
  task automatic cmd(ccs_cmd_type c, logic [1:0] s = 2'h0);
    if (c != CMD_RST) wait_hi(cmd_ready);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_slot = s;
    tk(1);
    cmd_valid = 1'b0;
    tk(1);
  endtask
  task automatic talk();
    ask = 1'b1;
    tk(1);
    ask = 1'b0;
    tk(4);
  endtask
  // ************
  // Scenarios
  // ************
  initial begin
    {cmd_valid, ovl_start, ovl_done, get_in, arm_src_bus, esr_rd, err_avail, ask} = '0;
    {cmd_slot, ev_set, ese, sre, cur_setup} = '0;
    cmd_code = CMD_NOP;
    meas_idle = 1'b1;
    mod_id = {16'h0000, 16'h1234};
    sys_rst = 1'b1;
    tk(12);
    sys_rst = 1'b0;
    chk("ready", cmd_ready, 1);
    chk("setup", setup_out, PRE);
    meas_idle = 1'b0;
    ovl_start = 1'b1;
    tk(1);
    ovl_start = 1'b0;
    cmd(CMD_OPC);
    tk(3);
    chk("opc_wait", esr[ESR_OPC], 0);
    ovl_done = 1'b1;
    tk(1);
    ovl_done = 1'b0;
    tk(3);
    chk("opc_idle", esr[ESR_OPC], 0);
    ese = 8'h01;
    sre = 8'h20;
    meas_idle = 1'b1;
    tk(3);
    chk("opc_set", esr[ESR_OPC], 1);
    chk("rqs_esb", stb[STB_RQS], 1);
    esr_rd = 1'b1;
    tk(1);
    esr_rd = 1'b0;
    sre = 8'h10;
    meas_idle = 1'b0;
    cmd(CMD_OPQ);
    tk(3);
    chk("opq_busy", cmd_ready, 0);
    chk("opq_hold", stb[STB_MAV], 0);
    meas_idle = 1'b1;
    tk(3);
    chk("mav", stb[STB_MAV], 1);
    chk("rqs_mav", stb[STB_RQS], 1);
    talk();
    chk("opq_char", rx_d, ASCII_ONE);
    chk("opq_kind", rx_k, ENT_CHAR);
    cmd(CMD_OPT);
    tk(3);
    talk();
    chk("opt_0", {rx_k, rx_d}, {ENT_MODEL, 16'h1234});
    talk();
    chk("opt_1", {rx_k, rx_d}, {ENT_NONE, NONE_WORD});
    cur_setup = 32'h0123abcd;
    cmd(CMD_SAV, 2'h2);
    cmd(CMD_OPC);
    cur_setup = 32'h00000000;
    cmd(CMD_RCL, 2'h2);
    wait_hi(setup_load);
    chk("rcl_2", setup_out, 32'h0123abcd);
    cmd(CMD_RCL, 2'h3);
    wait_hi(setup_load);
    chk("rcl_3", setup_out, PRE);
    meas_idle = 1'b0;
    cmd(CMD_OPQ);
    cmd(CMD_RST);
    meas_idle = 1'b1;
    tk(3);
    chk("rst_mav", stb[STB_MAV], 0);
    chk("rst_rdy", cmd_ready, 1);
    chk("rst_set", setup_out, PRE);
    cmd(CMD_TRG);
    tk(2);
    chk("trg_off", trg_n, 0);
    arm_src_bus = 1'b1;
    cmd(CMD_TRG);
    get_in = 1'b1;
    tk(1);
    get_in = 1'b0;
    tk(2);
    chk("trg_on", trg_n, 2);
    err_avail = 1'b1;
    ev_set = 8'h80;
    tk(1);
    ev_set = 8'h00;
    tk(2);
    chk("esr_ev", esr[7], 1);
    chk("eav", stb[STB_EAV], 1);
    cmd(CMD_CLS);
    chk("cls", esr, 8'h00);
    final_report();
  end
endmodule // tb_top
